// >>> tb/mcc_codec_model.sv
`timescale 1ns/10ps
module mcc_codec_model (
  input wire logic bit_clk_in,
  input wire logic link_reset_n_in,
  input wire logic sync_in,
  input wire logic sdout_in,
  input wire logic present_in,
  input wire logic ready_in,
  input wire logic [9:0] req_n_in,
  output logic sdin_out,
  output logic [15:0] tag_out,
  output logic [11:0][19:0] slot_out,
  output int frames_out
);
  logic sync_q;
  int cnt;
  logic [15:0] tag_acc;
  logic [11:0][19:0] slot_acc;
  logic [19:0] slot1;

  initial begin
    sdin_out = 1'b0;
    sync_q = 1'b0;
    cnt = 300;
    frames_out = 0;
    tag_out = 16'h0000;
    slot_out = '0;
    tag_acc = 16'h0000;
    slot_acc = '0;
  end

  // slot 1 carries active-low requests for slots 3..12 in bits 11:2
  assign slot1 = {8'h00, req_n_in, 2'b00};

  // both codecs run off the same bit clock, so rates always match
  always @(posedge bit_clk_in) begin
    if (sync_in && !sync_q) begin
      cnt = 0;
    end else if (cnt < 300) begin
      cnt = cnt + 1;
    end
    sync_q = sync_in;
    if (cnt < 16) begin
      tag_acc[15-cnt] = sdout_in;
    end else if (cnt < 256) begin
      slot_acc[(cnt-16)/20][19-(cnt-16)%20] = sdout_in;
    end
    if (cnt == 255) begin
      tag_out = tag_acc;
      slot_out = slot_acc;
      frames_out = frames_out + 1;
    end
    // an absent or reset codec leaves its line to the board pull-down
    if (!present_in || !link_reset_n_in || cnt >= 256) begin
      sdin_out <= 1'b0;
    end else if (cnt == 0) begin
      sdin_out <= ready_in;
    end else if (cnt >= 16 && cnt < 36) begin
      sdin_out <= ready_in ? slot1[35-cnt] : 1'b1;
    end else begin
      sdin_out <= 1'b0;
    end
  end
endmodule : mcc_codec_model

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
  import mcc_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic bit_clk = 1'b0;
  logic strap = 1'b0;
  mcc_chan_e mode = MCC_CH2;
  mcc_codec_e prim = MCC_AUDIO_ONLY;
  mcc_codec_e sec = MCC_NO_CODEC;
  logic cold = 1'b0;
  logic feed = 1'b0;
  logic took = 1'b0;
  logic [SAMPLE_W-1:0] sdata = 20'h00001;
  logic [1:0] sin;
  logic [9:0] req1_n = 10'h3FF;
  logic rdy1 = 1'b1;
  logic pres1 = 1'b0;
  logic sync, sdout, lrst_n, obrst_n, gpin, sec_en, cfg_ok, underrun, sready;
  logic [1:0] cready;
  logic [15:0] tag_p;
  logic [11:0][19:0] slots_p;
  int frames_p;
  int n_mismatch = 0;
  int n_compared = 0;

  always #25 clk_sys_in = ~clk_sys_in;
  initial begin
    #137;
    forever #200 bit_clk = ~bit_clk;
  end

  // handshake taken at the rising edge; next word presented at the fall
  always @(posedge clk_sys_in) took <= feed && sready;
  always @(negedge clk_sys_in) if (took) sdata <= sdata + 20'h00001;

  mcc_multi_codec_ctrl u_mcc_multi_codec_ctrl (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bit_clk_in(bit_clk),
    .serial_in_in(sin), .onboard_codec_disable_n_in(strap),
    .chan_mode_in(mode), .primary_type_in(prim), .secondary_type_in(sec),
    .cold_reset_in(cold), .sample_valid_in(feed),
    .sample_ready_out(sready), .sample_data_in(sdata),
    .link_sync_out(sync), .link_data_out(sdout),
    .link_reset_n_out(lrst_n), .onboard_codec_reset_n_out(obrst_n),
    .general_input_pin_out(gpin), .secondary_enable_out(sec_en),
    .config_valid_out(cfg_ok), .codec_ready_out(cready),
    .underrun_out(underrun)
  );

  mcc_codec_model u_mcc_codec_model (
    .bit_clk_in(bit_clk), .link_reset_n_in(obrst_n),
    .sync_in(sync), .sdout_in(sdout), .present_in(1'b1), .ready_in(1'b1),
    .req_n_in(10'h000), .sdin_out(sin[0]), .tag_out(tag_p),
    .slot_out(slots_p), .frames_out(frames_p)
  );
  // riser codec sits on the second serial line, clear of the on-board one
  mcc_codec_model u_mcc_codec_model_2 (
    .bit_clk_in(bit_clk), .link_reset_n_in(lrst_n),
    .sync_in(sync), .sdout_in(sdout), .present_in(pres1), .ready_in(rdy1),
    .req_n_in(req1_n), .sdin_out(sin[1]), .tag_out(),
    .slot_out(), .frames_out()
  );

  task automatic chk(input string what, input logic [19:0] exp,
                     input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc

  task automatic wait_frames(input int n);
    int f;
    int k;
    for (int i = 0; i < n; i++) begin
      f = frames_p;
      k = 0;
      while (frames_p == f && k < 3000) begin
        @(negedge clk_sys_in);
        k++;
      end
      if (k >= 3000) chk("frame_arrival", 20'h1, 20'h0);
    end
  endtask : wait_frames

  task automatic t_reset();
    cyc(10);
    chk("link_reset_n_early", 20'h0, 20'(lrst_n));
    cyc(15);
    chk("link_reset_n_late", 20'h1, 20'(lrst_n));
    $display("test reset done");
  endtask : t_reset

  task automatic t_strap();
    strap = 1'b1;
    cyc(5);
    chk("onboard_reset_n_hi", 20'h0, 20'(obrst_n));
    chk("gpin_hi", 20'h1, 20'(gpin));
    strap = 1'b0;
    cyc(5);
    chk("onboard_reset_n_lo", 20'h1, 20'(obrst_n));
    chk("gpin_lo", 20'h0, 20'(gpin));
    $display("test strap done");
  endtask : t_strap

  task automatic t_pairs();
    logic ok;
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        prim = mcc_codec_e'(p);
        sec = mcc_codec_e'(s);
        cyc(4);
        ok = (p == 1) || (p == 2 && s == 0) || (p == 3 && s < 2);
        chk("config_valid", 20'(ok), 20'(cfg_ok));
        chk("secondary_en", 20'(ok && s != 0), 20'(sec_en));
      end
    end
    prim = MCC_AUDIO_ONLY;
    sec = MCC_NO_CODEC;
    $display("test pairs done");
  endtask : t_pairs

  // last slot of the mode must hold the word off words after slot 3
  task automatic t_frame(input string name, input mcc_chan_e m,
                         input logic [15:0] etag, input int last,
                         input int off, input logic [1:0] erdy);
    mode = m;
    wait_frames(3);
    chk(name, 20'(etag), 20'(tag_p));
    chk("codec_ready", 20'(erdy), 20'(cready));
    if (etag != 16'h0000) begin
      chk("slot4", slots_p[2] + 20'h1, slots_p[3]);
      chk("last_slot", slots_p[2] + 20'(off), slots_p[last-1]);
    end
    $display("test %s done", name);
  endtask : t_frame

  task automatic t_underrun();
    int k;
    do @(negedge clk_sys_in); while (!took);
    feed = 1'b0;
    k = 0;
    while (underrun !== 1'b1 && k < 5000) begin
      @(negedge clk_sys_in);
      k++;
    end
    chk("underrun", 20'h1, 20'(underrun));
    wait_frames(2);
    chk("underrun_tag", 20'h09800, 20'(tag_p));
    chk("underrun_zero", 20'h0, slots_p[2]);
    $display("test underrun done");
  endtask : t_underrun

  task automatic t_cold();
    cold = 1'b1;
    cyc(1);
    cold = 1'b0;
    cyc(4);
    chk("cold_link_reset", 20'h0, 20'(lrst_n));
    chk("cold_onboard_reset", 20'h0, 20'(obrst_n));
    cyc(25);
    chk("cold_link_release", 20'h1, 20'(lrst_n));
    $display("test cold done");
  endtask : t_cold

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // about 20 frames of 2048 cycles are expected; allow half as much again
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    n_mismatch++;
    conclude();
  end

  initial begin
    cyc(20);
    rst_n_in = 1'b1;
    t_reset();
    t_strap();
    t_pairs();
    feed = 1'b1;
    t_frame("ch2", MCC_CH2, 16'h9800, 4, 1, 2'b01);
    sec = MCC_AUDIO_ONLY;
    pres1 = 1'b1;
    t_frame("ch4_hold", MCC_CH4, 16'h0000, 8, 3, 2'b11);
    req1_n = 10'h000;
    t_frame("ch4", MCC_CH4, 16'h9980, 8, 3, 2'b11);
    t_frame("ch6", MCC_CH6, 16'h9BC0, 9, 5, 2'b11);
    rdy1 = 1'b0;
    t_frame("ch6_not_ready", MCC_CH6, 16'h0000, 9, 5, 2'b01);
    t_frame("code2", mcc_chan_e'(2'h2), 16'h9800, 4, 1, 2'b01);
    t_underrun();
    t_cold();
    conclude();
  end
endmodule : tb

// >>> verilog/mcc_fifo.sv
`timescale 1ns/10ps
module mcc_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  mcc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic wr_fire;
  logic rd_fire;

  assign wr_fire = wr_valid_in && wr_ready_out;
  assign rd_fire = rd.valid && rd.ready;
  assign rd.valid = (count != '0);
  assign rd.data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (wr_fire && !rd_fire) next_count = count + 1'b1;
    if (rd_fire && !wr_fire) next_count = count - 1'b1;
  end

  // storage has no reset: contents are only read behind a valid count
  always_ff @(posedge clk_sys_in) begin
    if (wr_fire) mem[wr_ptr] <= wr_data_in;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      wr_ready_out <= 1'b0;
    end else begin
      if (wr_fire) wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      if (rd_fire) rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
      wr_ready_out <= (next_count != CNT_FULL);
    end
  end
endmodule : mcc_fifo

// >>> verilog/mcc_link_sync.sv
`timescale 1ns/10ps
module mcc_link_sync (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic bit_clk_in,
  input wire logic [1:0] serial_in,
  input wire logic strap_in,
  output logic bclk_rise_out,
  output logic bclk_fall_out,
  output logic [1:0] serial_out,
  output logic strap_out
);
  logic [3:0] raw;
  logic [3:0] meta;
  logic [3:0] stable;
  logic bclk_last;

  assign raw = {strap_in, serial_in, bit_clk_in};

  // all pins share one latency so serial data stays aligned to clock edges
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta[i] <= 1'b0;
        stable[i] <= 1'b0;
      end else begin
        meta[i] <= raw[i];
        stable[i] <= meta[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) bclk_last <= 1'b0;
    else bclk_last <= stable[0];
  end

  assign bclk_rise_out = stable[0] && !bclk_last;
  assign bclk_fall_out = !stable[0] && bclk_last;
  assign serial_out = stable[2:1];
  assign strap_out = stable[3];
endmodule : mcc_link_sync

// >>> verilog/mcc_multi_codec_ctrl.sv
// How it works
// RULE_01 - in 4 or 6 channel mode, send slot data only once all codecs request
// RULE_02 - two codecs run together on one link for surround output
// RULE_03 - both codecs share sample rate and compatible buffer depth
// RULE_04 - strap low keeps the on-board codec enabled as primary
// RULE_05 - strap high holds on-board codecs in reset; riser codecs lead (code still takes the primary from serial line 0)
// RULE_06 - never more than two codecs enabled on the link
// RULE_07 - strap level is readable by firmware on a general input pin
// RULE_08 - only the allowed primary and secondary codec pairings are enabled
// RULE_09 - controller drives the active-low link reset to the codecs
// RULE_10 - riser codec uses a serial input line not taken on board
// RULE_11 - every frame carries twelve outgoing and twelve incoming slots
// RULE_12 - on-board codec reset is link reset gated by the inverted strap
`timescale 1ns/10ps
module mcc_multi_codec_ctrl (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic bit_clk_in,
  input wire logic [1:0] serial_in_in,
  input wire logic onboard_codec_disable_n_in,
  input wire mcc_pkg::mcc_chan_e chan_mode_in,
  input wire mcc_pkg::mcc_codec_e primary_type_in,
  input wire mcc_pkg::mcc_codec_e secondary_type_in,
  input wire logic cold_reset_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic [mcc_pkg::SAMPLE_W-1:0] sample_data_in,
  output logic link_sync_out,
  output logic link_data_out,
  output logic link_reset_n_out,
  output logic onboard_codec_reset_n_out,
  output logic general_input_pin_out,
  output logic secondary_enable_out,
  output logic config_valid_out,
  output logic [1:0] codec_ready_out,
  output logic underrun_out
);
  import mcc_pkg::*;

  logic bclk_rise;
  logic bclk_fall;
  logic [1:0] serial_bit;
  logic strap;
  mcc_link_e state;
  logic [4:0] cold_cnt;
  logic [3:0] slot_idx;
  logic [4:0] slot_bit;
  logic [3:0] next_slot;
  logic [11:0] send_mask;
  logic [11:0] eff_mask;
  logic [11:0] need_req;
  logic [11:0] next_mask;
  logic [SAMPLE_W-1:0] shift;
  logic [SAMPLE_W-1:0] load_word;
  logic [11:0] req [NUM_CODECS];
  logic [SAMPLE_W-1:0] in_shift [NUM_CODECS];
  logic cfg_ok;
  logic sec_on;
  logic multi;
  logic all_req;
  logic running;
  logic frame_start;
  logic slot_load;

  mcc_stream_if stream ();

  mcc_link_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .bit_clk_in(bit_clk_in),
    .serial_in(serial_in_in),
    .strap_in(onboard_codec_disable_n_in),
    .bclk_rise_out(bclk_rise),
    .bclk_fall_out(bclk_fall),
    .serial_out(serial_bit),
    .strap_out(strap)
  );

  mcc_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_valid_in(sample_valid_in),
    .wr_ready_out(sample_ready_out),
    .wr_data_in(sample_data_in),
    .rd(stream.src)
  );

  // codec pairing; primary always sits on serial line 0, secondary on 1
  assign cfg_ok = pair_ok(primary_type_in, secondary_type_in); // RULE_08
  assign sec_on = cfg_ok && (secondary_type_in != MCC_NO_CODEC); // RULE_06
  // unmapped mode codes fall back to 2 channels and need no secondary
  assign multi = sec_on &&
                 (chan_mode_in == MCC_CH4 || chan_mode_in == MCC_CH6); // RULE_02
  assign eff_mask = !cfg_ok ? SLOTS_NONE :
                    (multi ? mode_slots(chan_mode_in) : SLOTS_2CH);
  // a slot is ready only when every codec taking part asked for it
  assign need_req = multi ? (req[0] & req[1]) : req[0]; // RULE_01
  assign all_req = ((eff_mask & ~need_req) == SLOTS_NONE); // RULE_01
  assign next_mask = all_req ? eff_mask : SLOTS_NONE; // RULE_01

  assign running = (state == MCC_ST_RUN);
  assign next_slot = (slot_idx == LAST_SLOT) ? 4'h0 : slot_idx + 4'h1;
  assign slot_load = bclk_rise && running && (slot_bit == 5'h00);
  assign frame_start = slot_load && (next_slot == 4'h0);
  assign stream.ready = slot_load && slot_sent(send_mask, next_slot);

  always_comb begin
    load_word = '0;
    if (next_slot == 4'h0) load_word = {(|next_mask), next_mask, 7'h00};
    else if (stream.ready && stream.valid) load_word = stream.data;
  end

  // link reset sequencing
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= MCC_ST_COLD;
    end else begin
      unique case (state)
        MCC_ST_COLD: begin
          if (cold_cnt == COLD_RESET_LAST) state <= MCC_ST_WAIT;
        end
        MCC_ST_WAIT: begin
          if (cold_reset_in) state <= MCC_ST_COLD;
          else if (bclk_rise) state <= MCC_ST_RUN;
        end
        MCC_ST_RUN: begin
          if (cold_reset_in) state <= MCC_ST_COLD;
        end
        default: state <= MCC_ST_COLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) cold_cnt <= 5'h00;
    else if (state == MCC_ST_COLD) cold_cnt <= cold_cnt + 5'h01;
    else cold_cnt <= 5'h00;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_reset_n_out <= 1'b0;
      onboard_codec_reset_n_out <= 1'b0;
      general_input_pin_out <= 1'b0;
      secondary_enable_out <= 1'b0;
      config_valid_out <= 1'b0;
    end else begin
      link_reset_n_out <= (state != MCC_ST_COLD); // RULE_09
      // strap high keeps on-board parts in reset whatever the link does
      onboard_codec_reset_n_out <= (state != MCC_ST_COLD) && !strap; // RULE_04 RULE_05 RULE_12
      general_input_pin_out <= strap; // RULE_07
      secondary_enable_out <= sec_on; // RULE_06
      config_valid_out <= cfg_ok; // RULE_08
    end
  end

  // slot position, moved on each rising link clock edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_idx <= LAST_SLOT;
      slot_bit <= 5'h00;
    end else if (!running) begin
      slot_idx <= LAST_SLOT;
      slot_bit <= 5'h00;
    end else if (slot_load) begin
      slot_idx <= next_slot; // RULE_11
      slot_bit <= (next_slot == 4'h0) ? TAG_LAST_BIT : SLOT_LAST_BIT; // RULE_11
    end else if (bclk_rise) begin
      slot_bit <= slot_bit - 5'h01;
    end
  end

  // the slot choice is frozen per frame so tag bits match the data sent
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) send_mask <= SLOTS_NONE;
    else if (!running) send_mask <= SLOTS_NONE;
    else if (frame_start) send_mask <= next_mask; // RULE_01
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift <= '0;
      link_data_out <= 1'b0;
      link_sync_out <= 1'b0;
      underrun_out <= 1'b0;
    end else begin
      underrun_out <= stream.ready && !stream.valid;
      if (!running) begin
        shift <= '0;
        link_data_out <= 1'b0;
        link_sync_out <= 1'b0;
      end else if (slot_load) begin
        shift <= load_word;
        link_data_out <= load_word[SAMPLE_W-1];
        link_sync_out <= (next_slot == 4'h0); // RULE_11
      end else if (bclk_rise) begin
        shift <= {shift[SAMPLE_W-2:0], 1'b0};
        link_data_out <= shift[SAMPLE_W-2];
      end
    end
  end

  // incoming slots sampled on falling edges, one capture per codec line
  for (genvar k = 0; k < NUM_CODECS; k++) begin : g_codec_in
    logic [SAMPLE_W-1:0] cap;
    assign cap = {in_shift[k][SAMPLE_W-2:0], serial_bit[k]};
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        in_shift[k] <= '0;
        codec_ready_out[k] <= 1'b0;
        req[k] <= SLOTS_NONE;
      end else if (!running) begin
        in_shift[k] <= '0;
        codec_ready_out[k] <= 1'b0;
        req[k] <= SLOTS_NONE;
      end else if (bclk_fall) begin
        in_shift[k] <= cap;
        // codecs answer one bit behind sync, so each field lands a bit late
        if (slot_bit == SLOT_LAST_BIT && slot_idx == 4'h1) begin
          codec_ready_out[k] <= cap[READY_BIT];
        end
        // requests are active low on the wire
        if (slot_bit == SLOT_LAST_BIT && slot_idx == 4'h2) begin
          req[k] <= codec_ready_out[k] ?
                    {2'b00, ~cap[REQ_HI:REQ_LO]} : SLOTS_NONE; // RULE_01
        end
      end
    end
  end

  // helper counters for the checks below
  logic [8:0] rise_cnt;
  logic [4:0] low_cnt;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) rise_cnt <= 9'h000;
    else if (!running) rise_cnt <= 9'h000;
    else if (frame_start) rise_cnt <= 9'h001;
    else if (bclk_rise && rise_cnt != 9'h000) rise_cnt <= rise_cnt + 9'h001;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) low_cnt <= 5'h00;
    else if (link_reset_n_out) low_cnt <= 5'h00;
    else if (low_cnt != LOW_CNT_MAX) low_cnt <= low_cnt + 5'h01;
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  property p_wait_req;
    frame_start && !all_req |=> send_mask == SLOTS_NONE;
  endproperty
  a_wait_req: assert property (p_wait_req) // RULE_01
    else $error("slot data sent before all requests");

  property p_surround;
    frame_start && all_req && multi && chan_mode_in == MCC_CH6
      |=> send_mask == SLOTS_6CH;
  endproperty
  a_surround: assert property (p_surround) // RULE_02
    else $error("six channel frame missing slots");

  property p_onboard_primary;
    (!onboard_codec_disable_n_in && link_reset_n_out) [*4]
      |-> onboard_codec_reset_n_out;
  endproperty
  a_onboard_primary: assert property (p_onboard_primary) // RULE_04
    else $error("on-board codec not released");

  property p_onboard_held;
    onboard_codec_disable_n_in [*3] |=> !onboard_codec_reset_n_out;
  endproperty
  a_onboard_held: assert property (p_onboard_held) // RULE_05
    else $error("on-board codec not held in reset");

  property p_two_max;
    secondary_enable_out
      |-> config_valid_out && $past(secondary_type_in) != MCC_NO_CODEC;
  endproperty
  a_two_max: assert property (p_two_max) // RULE_06
    else $error("secondary enabled without valid pair");

  property p_pairs;
    primary_type_in == MCC_MODEM_ONLY && secondary_type_in != MCC_NO_CODEC
      |=> !config_valid_out && !secondary_enable_out;
  endproperty
  a_pairs: assert property (p_pairs) // RULE_08
    else $error("invalid codec pairing accepted");

  property p_cold_len;
    $rose(link_reset_n_out) |-> $past(low_cnt) >= COLD_RESET_LAST;
  endproperty
  a_cold_len: assert property (p_cold_len) // RULE_09
    else $error("link reset pulse too short");

  property p_cold_req;
    cold_reset_in && running |-> ##2 !link_reset_n_out;
  endproperty
  a_cold_req: assert property (p_cold_req) // RULE_09
    else $error("link reset not driven on request");

  property p_frame_len;
    frame_start && rise_cnt != 9'h000 |-> rise_cnt == FRAME_BITS;
  endproperty
  a_frame_len: assert property (p_frame_len) // RULE_11
    else $error("frame length wrong");

  c_six_ch: cover property (frame_start && multi && all_req
                            && chan_mode_in == MCC_CH6);
  c_underrun: cover property (underrun_out);
  c_riser_lead: cover property (general_input_pin_out
                                && secondary_enable_out);
endmodule : mcc_multi_codec_ctrl

// >>> verilog/mcc_pkg.sv
package mcc_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int COLD_RESET_NS = 1000;
  localparam int COLD_RESET_CYC =
    (COLD_RESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [4:0] COLD_RESET_LAST = 5'(COLD_RESET_CYC - 1);
  localparam logic [4:0] LOW_CNT_MAX = 5'h1F;

  localparam int SAMPLE_W = 20;
  localparam int FIFO_DEPTH = 4;
  localparam int NUM_CODECS = 2;

  // frame layout: tag slot of 16 bits, then 12 slots of 20 bits
  localparam logic [3:0] LAST_SLOT = 4'hC;
  localparam logic [4:0] TAG_LAST_BIT = 5'h0F;
  localparam logic [4:0] SLOT_LAST_BIT = 5'h13;
  localparam logic [8:0] FRAME_BITS = 9'h100;
  localparam int READY_BIT = 15;
  localparam int REQ_HI = 11;
  localparam int REQ_LO = 2;

  // slot masks: bit 11 is slot 1, bit 0 is slot 12
  localparam logic [11:0] SLOTS_NONE = 12'h000;
  localparam logic [11:0] SLOTS_2CH = 12'h300;
  localparam logic [11:0] SLOTS_4CH = 12'h330;
  localparam logic [11:0] SLOTS_6CH = 12'h378;

  typedef enum logic [1:0] {
    MCC_CH2 = 2'h0,
    MCC_CH4 = 2'h1,
    MCC_CH6 = 2'h3
  } mcc_chan_e;

  typedef enum logic [1:0] {
    MCC_NO_CODEC = 2'h0,
    MCC_AUDIO_ONLY = 2'h1,
    MCC_MODEM_ONLY = 2'h2,
    MCC_AUDIO_MODEM_COMBO = 2'h3
  } mcc_codec_e;

  typedef enum logic [1:0] {
    MCC_ST_COLD = 2'h0,
    MCC_ST_WAIT = 2'h1,
    MCC_ST_RUN = 2'h3
  } mcc_link_e;

  function automatic logic [11:0] mode_slots(input mcc_chan_e mode);
    unique case (mode)
      MCC_CH2: mode_slots = SLOTS_2CH;
      MCC_CH4: mode_slots = SLOTS_4CH;
      MCC_CH6: mode_slots = SLOTS_6CH;
      default: mode_slots = SLOTS_2CH;
    endcase
  endfunction : mode_slots

  function automatic logic pair_ok(input mcc_codec_e prim,
                                   input mcc_codec_e sec);
    unique case (prim)
      MCC_NO_CODEC: pair_ok = 1'b0;
      MCC_AUDIO_ONLY: pair_ok = 1'b1;
      MCC_MODEM_ONLY: pair_ok = (sec == MCC_NO_CODEC);
      MCC_AUDIO_MODEM_COMBO:
        pair_ok = (sec == MCC_NO_CODEC) || (sec == MCC_AUDIO_ONLY);
    endcase
  endfunction : pair_ok

  function automatic logic slot_sent(input logic [11:0] mask,
                                     input logic [3:0] slot);
    slot_sent = (slot == 4'h0) ? 1'b0 : mask[4'(LAST_SLOT - slot)];
  endfunction : slot_sent

endpackage : mcc_pkg

// >>> verilog/mcc_stream_if.sv
`timescale 1ns/10ps
interface mcc_stream_if;
  import mcc_pkg::*;
  logic valid;
  logic ready;
  logic [SAMPLE_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mcc_stream_if
